// File: rtl/asc_capture.v
// Aperture sample capture: clock select, time stamp, comparator, FIFO and registers
`timescale 1ns/1ps
`include "asc_regs.vh"
module asc_capture #(
  parameter FIFO_AW     = 15,
  parameter SLOW_CYCLES = `ASC_SLOW_CYCLES
) (
  input  wire        clk_in,                      // Module clock, 100 MHz
  input  wire        rst_in,                      // Async reset, active high
  input  wire [7:0]  reg_addr_in,                 // Register byte address
  input  wire        reg_wr_in,                   // Write strobe, one cycle
  input  wire        reg_rd_in,                   // Read strobe, one cycle
  input  wire [15:0] reg_wdata_in,                // Write data
  output reg  [15:0] reg_rdata_out,               // Read data
  output reg         reg_ack_out,                 // Access done
  input  wire        front_panel_sample_clock_in, // Panel clock pin
  input  wire        front_panel_run_in,          // Panel run pin
  input  wire        trig_a_in,                   // Backplane trigger A
  input  wire        trig_b_in,                   // Backplane trigger B
  output reg         adc_start_out,               // Converter start pulse
  input  wire        adc_busy_in,                 // Converter busy pin
  input  wire [11:0] adc_data_in,                 // Converter result
  output wire [1:0]  trim_sel_out,                // Trim pot select
  output wire        trim_up_out,                 // Trim direction
  output wire        trim_clk_out,                // Trim step clock
  output wire        add_on_en_out,               // Add-on board pass enable
  output wire [3:0]  add_on_ctl_out               // Add-on board control
);

  localparam ST_IDLE = 2'b00;
  localparam ST_HI   = 2'b01;
  localparam ST_LO   = 2'b10;
  localparam W_UPPER = 2'b00;
  localparam W_LOWER = 2'b01;
  localparam W_VALUE = 2'b10;

  // Prescaler decode, used for count end
  function [3:0] psc_div;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   psc_div = 4'h1;
        2'b01:   psc_div = 4'h2;
        2'b10:   psc_div = 4'h5;
        default: psc_div = 4'hA;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  reg  [4:0]  sync3_q;
  reg  [11:0] adc1_q;
  reg  [11:0] adc2_q;
  wire [4:0]  pin_now;
  wire [4:0]  pin_rise;
  wire [4:0]  pin_fall;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
      adc1_q  <= `ASC_RST_SAMPLE;
      adc2_q  <= `ASC_RST_SAMPLE;
    end else begin
      sync1_q <= {adc_busy_in, trig_b_in, trig_a_in, front_panel_run_in,
                  front_panel_sample_clock_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      adc1_q  <= adc_data_in;
      adc2_q  <= adc1_q;
    end
  end

  assign pin_now  = sync2_q;
  assign pin_rise = sync2_q & ~sync3_q;
  assign pin_fall = ~sync2_q & sync3_q;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg  [1:0]  psc_q;
  reg  [2:0]  clk_sel_q;
  reg         store_all_q;
  reg  [2:0]  run_sel_q;
  reg         run_bit_q;
  reg         ds_q;
  reg         ff_q;
  reg         hf_q;
  reg         cse_q;
  reg  [2:0]  irq_en_q;
  reg  [11:0] upper_q;
  reg  [11:0] lower_q;
  reg  [15:0] trim_q;
  reg  [15:0] add_on_q;
  wire        wr_ctrl;
  wire        conv_req;
  wire        fifo_flush;
  wire        ts_clear;
  wire        set_ds;
  wire        set_ff;
  wire        set_hf;

  assign wr_ctrl    = reg_wr_in && (reg_addr_in == `ASC_OFS_CTRL);
  assign conv_req   = wr_ctrl && reg_wdata_in[`ASC_CTRL_CONV];
  assign fifo_flush = wr_ctrl && reg_wdata_in[`ASC_CTRL_RFF];
  assign ts_clear   = wr_ctrl && reg_wdata_in[`ASC_CTRL_RTS];

  assign trim_sel_out   = trim_q[5:4];
  assign trim_up_out    = trim_q[1];
  assign trim_clk_out   = trim_q[0];
  assign add_on_en_out  = add_on_q[15];
  assign add_on_ctl_out = add_on_q[3:0];

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      psc_q       <= 2'b00;
      clk_sel_q   <= 3'b000;
      store_all_q <= 1'b0;
      run_sel_q   <= 3'b000;
      run_bit_q   <= 1'b0;
      ds_q        <= 1'b0;
      ff_q        <= 1'b0;
      hf_q        <= 1'b0;
      irq_en_q    <= 3'b000;
      upper_q     <= `ASC_RST_SAMPLE;
      lower_q     <= `ASC_RST_SAMPLE;
      trim_q      <= `ASC_RST_REG16;
      add_on_q    <= `ASC_RST_REG16;
    end else begin
      if (wr_ctrl) begin
        psc_q       <= reg_wdata_in[`ASC_CTRL_PSC_HI:`ASC_CTRL_PSC_LO];
        clk_sel_q   <= reg_wdata_in[`ASC_CTRL_CLK_HI:`ASC_CTRL_CLK_LO];
        store_all_q <= reg_wdata_in[`ASC_CTRL_STA];
        run_sel_q   <= reg_wdata_in[`ASC_CTRL_RUN_HI:`ASC_CTRL_RUN_LO];
        run_bit_q   <= reg_wdata_in[`ASC_CTRL_RUN];
      end else if (reg_wr_in && reg_addr_in == `ASC_OFS_IRQ_EN) begin
        irq_en_q <= reg_wdata_in[15:13];
      end else if (reg_wr_in && reg_addr_in == `ASC_OFS_UPPER_WIN) begin
        upper_q <= reg_wdata_in[15:4];
      end else if (reg_wr_in && reg_addr_in == `ASC_OFS_LOWER_WIN) begin
        lower_q <= reg_wdata_in[15:4];
      end else if (reg_wr_in && reg_addr_in == `ASC_OFS_TRIM) begin
        trim_q <= {10'h000, reg_wdata_in[5:4], 2'b00, reg_wdata_in[1:0]};
      end else if (reg_wr_in && reg_addr_in == `ASC_OFS_ADD_ON) begin
        add_on_q <= {reg_wdata_in[15], 11'h000, reg_wdata_in[3:0]};
      end
      // Sticky status: a new event wins over a write-one clear
      ds_q <= set_ds | (ds_q & ~(wr_ctrl & reg_wdata_in[`ASC_CTRL_DS]));
      ff_q <= set_ff | (ff_q & ~(wr_ctrl & reg_wdata_in[`ASC_CTRL_FF]));
      hf_q <= set_hf | (hf_q & ~(wr_ctrl & reg_wdata_in[`ASC_CTRL_HF]));
    end
  end

  // ----------------------------------------------------------------------
  // Conversion clock and prescaler
  // ----------------------------------------------------------------------
  localparam [13:0] FAST_END = `ASC_FAST_CYCLES - 1;

  reg  [13:0] base_cnt_q;
  reg  [3:0]  psc_cnt_q;
  reg  [13:0] gap_cnt_q;
  reg         src_tick;
  wire [13:0] base_end;
  wire        base_tick;
  wire        pre_tick;

  // Internal 100 kHz or 10 kHz base
  assign base_end  = clk_sel_q[0] ? SLOW_CYCLES[13:0] - 14'h0001
                                  : FAST_END;
  assign base_tick = (base_cnt_q >= base_end);

  always @* begin
    case (clk_sel_q[2:1])
      2'b00:   src_tick = base_tick;
      2'b01:   src_tick = clk_sel_q[0] ? pin_fall[0] : pin_rise[0];
      2'b10:   src_tick = clk_sel_q[0] ? pin_fall[2] : pin_rise[2];
      default: src_tick = clk_sel_q[0] ? pin_fall[3] : pin_rise[3];
    endcase
  end

  assign pre_tick = src_tick && (psc_cnt_q + 4'h1 >= psc_div(psc_q));

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      base_cnt_q <= 14'h0000;
      psc_cnt_q  <= 4'h0;
      gap_cnt_q  <= 14'h0000;
      cse_q      <= 1'b0;
    end else begin
      base_cnt_q <= base_tick ? 14'h0000 : base_cnt_q + 14'h0001;
      if (pre_tick) begin
        psc_cnt_q <= 4'h0;
      end else if (src_tick) begin
        psc_cnt_q <= psc_cnt_q + 4'h1;
      end
      // Flag ticks closer than 10 us
      if (pre_tick) begin
        gap_cnt_q <= 14'h0000;
        cse_q     <= (gap_cnt_q < `ASC_MIN_GAP_CYCLES - 14'h0001);
      end else if (gap_cnt_q != 14'h3FFF) begin
        gap_cnt_q <= gap_cnt_q + 14'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Run source, time stamp and conversion sequence
  // ----------------------------------------------------------------------
  reg         run_now;
  reg         run_q;
  reg         first_q;
  reg         final_q;
  reg         force_q;
  reg  [1:0]  st_q;
  reg  [30:0] ts_q;
  reg  [30:0] ts_hold_q;
  reg  [11:0] ref_q;
  wire        launch;
  wire        launch_force;
  wire        done;
  wire        keep;
  wire        fifo_in_ready;
  wire [FIFO_AW:0] fifo_count;

  always @* begin
    case (run_sel_q)
      3'b000:  run_now = run_bit_q;
      3'b010:  run_now = pin_now[1];
      3'b011:  run_now = ~pin_now[1];
      3'b100:  run_now = pin_now[2];
      3'b101:  run_now = ~pin_now[2];
      3'b110:  run_now = pin_now[3];
      3'b111:  run_now = ~pin_now[3];
      default: run_now = 1'b0;
    endcase
  end

  assign launch_force = (final_q || (conv_req && !run_now)) && st_q == ST_IDLE;
  assign launch       = launch_force || (pre_tick && run_now && st_q == ST_IDLE);
  assign done         = (st_q == ST_LO) && !pin_now[4];

  // Outside the window around the reference
  assign keep = force_q || store_all_q
             || (adc2_q > ref_q && (adc2_q - ref_q) >= upper_q)
             || (adc2_q < ref_q && (ref_q - adc2_q) >= lower_q);
  assign set_ds = done && keep && fifo_in_ready;
  assign set_ff = done && keep && !fifo_in_ready;
  assign set_hf = fifo_count >= (1 << (FIFO_AW - 1));

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q         <= 1'b0;
      first_q       <= 1'b0;
      final_q       <= 1'b0;
      force_q       <= 1'b0;
      st_q          <= ST_IDLE;
      ts_q          <= `ASC_RST_TS;
      ts_hold_q     <= `ASC_RST_TS;
      ref_q         <= `ASC_RST_SAMPLE;
      adc_start_out <= 1'b0;
    end else begin
      run_q         <= run_now;
      adc_start_out <= launch;
      if (run_now && !run_q) begin
        first_q <= 1'b1;
      end else if (launch) begin
        first_q <= 1'b0;
      end
      // One final forced capture on disable
      if (!run_now && run_q) begin
        final_q <= 1'b1;
      end else if (launch) begin
        final_q <= 1'b0;
      end
      // One step per paced edge; wraps
      if (ts_clear) begin
        ts_q <= `ASC_RST_TS;
      end else if (pre_tick) begin
        ts_q <= ts_q + 31'h00000001;
      end
      case (st_q)
        ST_IDLE: begin
          if (launch) begin
            st_q      <= ST_HI;
            force_q   <= launch_force || first_q;
            ts_hold_q <= ts_q;
          end
        end
        ST_HI: begin
          if (pin_now[4]) begin
            st_q <= ST_LO;
          end
        end
        ST_LO: begin
          if (!pin_now[4]) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (set_ds) begin
        ref_q <= adc2_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pair FIFO and read port
  // ----------------------------------------------------------------------
  reg  [1:0]  word_q;
  reg  [31:0] hold_q;
  wire        fifo_out_valid;
  wire [47:0] fifo_out_data;
  wire        rd_port;
  wire        pop;
  wire [FIFO_AW+16:0] cnt_wide;

  // Zero-extend then cut to the 16-bit register width
  assign cnt_wide = {16'h0000, fifo_count};

  assign rd_port = reg_rd_in && (reg_addr_in == `ASC_OFS_PAIR_PORT);
  assign pop     = rd_port && word_q == W_UPPER && fifo_out_valid;

  // 32K pairs of 48 bits; in order
  asc_fifo #(
    .WIDTH (48),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .flush_in      (fifo_flush),
    .in_valid_in   (done && keep),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({1'b0, ts_hold_q, adc2_q, 4'h0}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (pop),
    .out_data_out  (fifo_out_data),
    .count_out     (fifo_count)
  );

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_q        <= W_UPPER;
      hold_q        <= 32'h00000000;
      reg_rdata_out <= `ASC_RST_REG16;
      reg_ack_out   <= 1'b0;
    end else begin
      reg_ack_out <= reg_rd_in | reg_wr_in;
      // Flush restarts at the upper word
      if (fifo_flush) begin
        word_q <= W_UPPER;
      end else if (rd_port) begin
        // Three words per pair; the upper word advances only on valid
        case (word_q)
          W_UPPER: word_q <= fifo_out_valid ? W_LOWER : W_UPPER;
          W_LOWER: word_q <= W_VALUE;
          default: word_q <= W_UPPER;
        endcase
      end
      if (pop) begin
        hold_q <= fifo_out_data[31:0];
      end
      if (reg_rd_in) begin
        if (reg_addr_in == `ASC_OFS_CTRL) begin
          reg_rdata_out <= {ds_q, ff_q, hf_q, psc_q, clk_sel_q, store_all_q,
                            run_sel_q, 2'b00, cse_q, run_bit_q};
        end else if (reg_addr_in == `ASC_OFS_IRQ_EN) begin
          reg_rdata_out <= {irq_en_q, 13'h0000};
        end else if (reg_addr_in == `ASC_OFS_UPPER_WIN) begin
          reg_rdata_out <= {upper_q, 4'h0};
        end else if (reg_addr_in == `ASC_OFS_LOWER_WIN) begin
          reg_rdata_out <= {lower_q, 4'h0};
        end else if (rd_port && word_q == W_UPPER) begin
          reg_rdata_out <= fifo_out_valid ? {1'b1, fifo_out_data[46:32]} : 16'h0000;
        end else if (rd_port && word_q == W_LOWER) begin
          reg_rdata_out <= hold_q[31:16];
        end else if (rd_port) begin
          reg_rdata_out <= hold_q[15:0];
        end else if (reg_addr_in == `ASC_OFS_TRIM) begin
          reg_rdata_out <= trim_q;
        end else if (reg_addr_in == `ASC_OFS_ADD_ON) begin
          reg_rdata_out <= add_on_q;
        end else if (reg_addr_in == `ASC_OFS_LAST_KEPT) begin
          reg_rdata_out <= {ref_q, 4'h0};
        end else if (reg_addr_in == `ASC_OFS_UNREAD) begin
          reg_rdata_out <= cnt_wide[15:0];
        end else begin
          reg_rdata_out <= 16'h0000;
        end
      end
    end
  end

endmodule

// File: rtl/asc_regs.vh
// Register map, field positions, reset values and timing counts for the capture block
`ifndef ASC_REGS_VH
`define ASC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the module bus)
// ----------------------------------------------------------------------
`define ASC_OFS_CTRL        8'h00
`define ASC_OFS_IRQ_EN      8'h02
`define ASC_OFS_UPPER_WIN   8'h04
`define ASC_OFS_LOWER_WIN   8'h06
`define ASC_OFS_PAIR_PORT   8'h08
`define ASC_OFS_TRIM        8'h0A
`define ASC_OFS_ADD_ON      8'h0C
`define ASC_OFS_LAST_KEPT   8'h0E
`define ASC_OFS_UNREAD      8'h10

// ----------------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------------
`define ASC_CTRL_DS         15
`define ASC_CTRL_FF         14
`define ASC_CTRL_HF         13
`define ASC_CTRL_PSC_HI     12
`define ASC_CTRL_PSC_LO     11
`define ASC_CTRL_CLK_HI     10
`define ASC_CTRL_CLK_LO     8
`define ASC_CTRL_STA        7
`define ASC_CTRL_RUN_HI     6
`define ASC_CTRL_RUN_LO     4
`define ASC_CTRL_CONV       3
`define ASC_CTRL_RFF        2
`define ASC_CTRL_RTS        1
`define ASC_CTRL_CSE        1
`define ASC_CTRL_RUN        0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ASC_RST_REG16       16'h0000
`define ASC_RST_TS          31'h00000000
`define ASC_RST_SAMPLE      12'h000

// ----------------------------------------------------------------------
// Timing: times in ns, counts derived from the 10 ns clock
// ----------------------------------------------------------------------
`define ASC_CLK_PERIOD_NS   10
`define ASC_FAST_BASE_NS    10000
`define ASC_SLOW_BASE_NS    100000
`define ASC_MIN_GAP_NS      10000
`define ASC_FAST_CYCLES     (`ASC_FAST_BASE_NS / `ASC_CLK_PERIOD_NS)
`define ASC_SLOW_CYCLES     (`ASC_SLOW_BASE_NS / `ASC_CLK_PERIOD_NS)
`define ASC_MIN_GAP_CYCLES  (`ASC_MIN_GAP_NS / `ASC_CLK_PERIOD_NS)

`endif

// File: rtl/asc_fifo.v
// Show-ahead FIFO of time-value pairs with flush and fill count
`timescale 1ns/1ps
module asc_fifo #(
  parameter WIDTH = 48,
  parameter AW    = 15
) (
  input  wire             clk_in,        // Module clock
  input  wire             rst_in,        // Async reset, active high
  input  wire             flush_in,      // Empty the FIFO
  input  wire             in_valid_in,   // Write request
  output wire             in_ready_out,  // Space available
  input  wire [WIDTH-1:0] in_data_in,    // Write data
  output wire             out_valid_out, // Entry available
  input  wire             out_ready_in,  // Pop request
  output wire [WIDTH-1:0] out_data_out,  // Oldest entry
  output wire [AW:0]      count_out      // Entries held
);

  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            push;
  wire            pop;

  assign count_out     = wr_q - rd_q;
  assign in_ready_out  = (count_out != DEPTH) && !flush_in;
  assign out_valid_out = (wr_q != rd_q) && !flush_in;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  always @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  // ----------------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

// File: testbench/asc_capture_sva.sv
// Checker for register port and converter link of the capture block
`timescale 1ns/1ps
module asc_capture_sva (
  input wire        clk_in,        // Module clock
  input wire        rst_in,        // Reset
  input wire [7:0]  reg_addr_in,   // Address
  input wire        reg_wr_in,     // Write strobe
  input wire        reg_rd_in,     // Read strobe
  input wire [15:0] reg_wdata_in,  // Write data
  input wire [15:0] reg_rdata_out, // Read data
  input wire        reg_ack_out,   // Ack
  input wire        adc_start_out, // Start
  input wire        adc_busy_in    // Busy
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reg       port_q;
  reg [1:0] ph_q;
  // ----
  // Pair port word tracking
  // ----
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_q <= 1'b0;
      ph_q   <= 2'h0;
    end else begin
      port_q <= reg_rd_in && reg_addr_in == 8'h08;
      if (reg_wr_in && reg_addr_in == 8'h00 && reg_wdata_in[2])
        ph_q <= 2'h0;
      else if (reg_ack_out && port_q)
        ph_q <= (ph_q == 2'h0) ? {1'b0, reg_rdata_out[15]} : {ph_q == 2'h1, 1'b0};
    end
  end
  property p_ack_next; (reg_rd_in || reg_wr_in) |=> reg_ack_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_cause; reg_ack_out |-> $past(reg_rd_in) || $past(reg_wr_in); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmapped; reg_rd_in && reg_addr_in == 8'h12 |=> reg_rdata_out == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_win_nib;
    reg_rd_in && (reg_addr_in == 8'h04 || reg_addr_in == 8'h06) |=> reg_rdata_out[3:0] == 4'h0;
  endproperty
  a_win_nib: assert property (p_win_nib) else $error("window low nibble set");
  property p_smp_nib; reg_ack_out && port_q && ph_q == 2'h2 |-> reg_rdata_out[3:0] == 4'h0; endproperty
  a_smp_nib: assert property (p_smp_nib) else $error("sample low nibble set");
  property p_pulse_bits; reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out[3:2] == 2'b00; endproperty
  a_pulse_bits: assert property (p_pulse_bits) else $error("pulse bits read back");
  property p_start_one; adc_start_out |=> !adc_start_out; endproperty
  a_start_one: assert property (p_start_one) else $error("start too long");
  property p_start_idle; adc_busy_in |-> !adc_start_out; endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while busy");
  c_sample: cover property (reg_ack_out && port_q && ph_q == 2'h2);
  c_start: cover property (adc_start_out);
  c_unmapped: cover property (reg_rd_in && reg_addr_in == 8'h12);
endmodule
bind asc_capture asc_capture_sva u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_ack_out(reg_ack_out),
  .adc_start_out(adc_start_out), .adc_busy_in(adc_busy_in));

// File: testbench/asc_adc_model.sv
// Converter model: busy after start, result held briefly past busy fall
`timescale 1ns/1ps
module asc_adc_model #(
  parameter [7:0] CONV = 8'h1E
) (
  input  wire        clk_in,    // Module clock
  input  wire        rst_in,    // Reset
  input  wire        start_in,  // Start pulse
  input  wire [11:0] sample_in, // Value to convert
  output wire        busy_out,  // Busy
  output wire [11:0] data_out,  // Result bus
  output reg  [7:0]  n_conv_out // Conversions started
);
  reg [7:0]  cnt_q;
  reg [11:0] smp_q;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q      <= 8'h00;
      smp_q      <= 12'h000;
      n_conv_out <= 8'h00;
    end else if (start_in) begin
      cnt_q      <= CONV + 8'h08;
      smp_q      <= sample_in;
      n_conv_out <= n_conv_out + 8'h01;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign busy_out = cnt_q > 8'h08;
  assign data_out = (cnt_q != 8'h00 && cnt_q <= 8'h0B) ? smp_q : ~smp_q;
endmodule

// File: testbench/aperture_sample_capture_tb.sv
// Self-checking bench for the aperture sample capture block
`timescale 1ns/1ps
module aperture_sample_capture_tb;
  reg         clk_in  = 1'b0;
  reg         rst_in  = 1'b1;
  reg  [7:0]  addr    = 8'h00;
  reg         wr      = 1'b0;
  reg         rd      = 1'b0;
  reg  [15:0] wdata   = 16'h0000;
  reg         run_pin = 1'b0;
  reg         pclk    = 1'b0;
  reg  [11:0] tbl [0:7];
  reg  [15:0] rv;
  reg  [31:0] t1;
  reg  [31:0] t2;
  reg  [15:0] s;
  wire [15:0] rdata;
  wire        ack;
  wire        start;
  wire        busy;
  wire [11:0] adc_q;
  wire [1:0]  tsel;
  wire        tup;
  wire        tclk;
  wire        aen;
  wire [3:0]  actl;
  wire [7:0]  n_conv;
  integer     err_total  = 0;
  integer     num_checks = 0;
  always #5 clk_in = ~clk_in;
  asc_capture #(.FIFO_AW(4), .SLOW_CYCLES(100)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack),
    .front_panel_sample_clock_in(pclk), .front_panel_run_in(run_pin), .trig_a_in(1'b0),
    .trig_b_in(1'b0), .adc_start_out(start), .adc_busy_in(busy), .adc_data_in(adc_q),
    .trim_sel_out(tsel), .trim_up_out(tup), .trim_clk_out(tclk), .add_on_en_out(aen),
    .add_on_ctl_out(actl));
  asc_adc_model u_adc (.clk_in(clk_in), .rst_in(rst_in), .start_in(start),
    .sample_in(tbl[n_conv[2:0]]), .busy_out(busy), .data_out(adc_q), .n_conv_out(n_conv));
  // ----
  // Shared tasks
  // ----
  task chk(input [47:0] got, input [47:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input we, input [7:0] a, input [15:0] d);
    begin
      @(negedge clk_in);
      addr = a;
      wdata = d;
      wr = we;
      rd = !we;
      @(negedge clk_in);
      chk(ack, 1'b1);
      rv = rdata;
      wr = 1'b0;
      rd = 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [15:0] e);
    begin
      bus(1'b0, a, 16'h0000);
      chk(rv, e);
    end
  endtask
  task wait_conv(input [7:0] n);
    integer i;
    begin
      for (i = 0; i < 40000 && n_conv != n; i = i + 1)
        @(negedge clk_in);
      chk(n_conv, n);
      repeat (80) @(negedge clk_in);
    end
  endtask
  task pair(output [31:0] ts, output [15:0] smp);
    reg [15:0] hi;
    begin
      bus(1'b0, 8'h08, 16'h0000);
      hi = rv;
      chk(hi[15], 1'b1);
      bus(1'b0, 8'h08, 16'h0000);
      ts = {1'b0, hi[14:0], rv};
      bus(1'b0, 8'h08, 16'h0000);
      smp = rv;
    end
  endtask
  task print_verdict;
    begin
      if (err_total == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    begin
      rchk(8'h00, 16'h0000);
      bus(1'b0, 8'h08, 16'h0000);
      chk(rv[15], 1'b0);
      bus(1'b1, 8'h04, 16'hABCF);
      bus(1'b1, 8'h0A, 16'h0033);
      bus(1'b1, 8'h0C, 16'h800A);
      bus(1'b1, 8'h02, 16'hE000);
      rchk(8'h04, 16'hABC0);
      rchk(8'h02, 16'hE000);
      rchk(8'h12, 16'h0000);
      chk({tsel, tup, tclk, aen, actl}, 9'h1FA);
      bus(1'b1, 8'h04, 16'h1000);
      bus(1'b1, 8'h06, 16'hFFF0);
    end
  endtask
  task t_manual;
    begin
      bus(1'b1, 8'h00, 16'h0008);
      wait_conv(8'd1);
      pair(t1, s);
      chk(s, 16'hABC0);
      bus(1'b0, 8'h08, 16'h0000);
      chk(rv[15], 1'b0);
      bus(1'b0, 8'h08, 16'h0000);
      chk(rv[15], 1'b0);
    end
  endtask
  task t_run;
    begin
      bus(1'b1, 8'h00, 16'h0003);
      wait_conv(8'd5);
      bus(1'b1, 8'h00, 16'h0000);
      wait_conv(8'd6);
      rchk(8'h10, 16'h0003);
      pair(t1, s);
      chk({t1, s}, 48'h0000_0000_2000);
      pair(t1, s);
      chk({t1, s}, 48'h0000_0002_3000);
      pair(t1, s);
      chk({t1, s}, 48'h0000_0004_2FF0);
    end
  endtask
  task t_full;
    begin
      bus(1'b1, 8'h00, 16'h00A2);
      repeat (2500) @(negedge clk_in);
      chk(n_conv, 8'd6);
      run_pin = 1'b1;
      bus(1'b1, 8'h00, 16'h00A2);
      wait_conv(8'd24);
      run_pin = 1'b0;
      wait_conv(8'd25);
      rchk(8'h00, 16'hE0A0);
      rchk(8'h10, 16'h0010);
      pair(t1, s);
      chk(t1, 32'h0);
      pair(t2, s);
      chk(t2, t1 + 32'd1);
      bus(1'b0, 8'h08, 16'h0000);
      chk(rv[15], 1'b1);
      bus(1'b1, 8'h00, 16'hE004);
      rchk(8'h10, 16'h0000);
      rchk(8'h08, 16'h0000);
    end
  endtask
  task t_clk;
    integer k;
    begin
      bus(1'b1, 8'h06, 16'h0010);
      bus(1'b1, 8'h00, 16'h0A03);
      for (k = 0; k < 8; k = k + 1) begin
        repeat (50) @(negedge clk_in);
        pclk = 1'b1;
        repeat (50) @(negedge clk_in);
        pclk = 1'b0;
      end
      wait_conv(8'd29);
      bus(1'b1, 8'h00, 16'h0000);
      wait_conv(8'd30);
      rchk(8'h10, 16'h0004);
      bus(1'b0, 8'h00, 16'h0000);
      chk(rv[1], 1'b1);
      pair(t1, s);
      chk({t1, s}, 48'h0000_0000_2000);
      pair(t1, s);
      chk({t1, s}, 48'h0000_0002_3000);
      pair(t1, s);
      chk({t1, s}, 48'h0000_0003_2FF0);
    end
  endtask
  // ----
  // Main
  // ----
  initial begin
    tbl[0] = 12'hABC;
    tbl[1] = 12'h200;
    tbl[2] = 12'h250;
    tbl[3] = 12'h300;
    for (int i = 4; i < 8; i++)
      tbl[i] = 12'h2FF;
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    t_regs;
    t_manual;
    t_run;
    t_full;
    t_clk;
    print_verdict;
  end
  initial begin
    #800000;
    err_total = err_total + 1;
    print_verdict;
  end
endmodule
